// ===== rtl/srac_pkg.sv
// Package for the two-wire slave address and access control block.
// Assumes one 200 MHz system clock; bus pins arrive asynchronously.
`default_nettype none
package srac_pkg;
  // Clock and bus timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int BUS_MAX_KHZ = 1000;
  localparam int BUS_MIN_PERIOD_NS = 1000000 / BUS_MAX_KHZ;
  localparam int BUS_PERIOD_CYC = BUS_MIN_PERIOD_NS / CLK_PERIOD_NS;
  // Register offsets
  localparam logic [7:0] OFS_BASE_ADDR = 8'h40;
  localparam logic [7:0] OFS_ADDR_CFG = 8'h42;
  localparam logic [7:0] OFS_ADDR_LOCK = 8'hD4;
  localparam logic [7:0] OFS_SEC_CTRL = 8'hD6;
  localparam logic [7:0] OFS_PWD_KEY = 8'hD8;
  localparam logic [7:0] OFS_PWD_STORE = 8'hDA;
  localparam logic [7:0] OFS_NVM_PROG = 8'hE0;
  localparam logic [7:0] OFS_TEL_LO = 8'h80;
  localparam logic [7:0] OFS_TEL_HI = 8'h87;
  localparam int TEL_N = 8;
  // Field positions
  localparam int FLD_PMB_LSB = 0;
  localparam int FLD_I2C_LSB = 8;
  localparam int FLD_OFS_DIS = 6;
  localparam int FLD_ADDR_LOCK = 2;
  localparam int FLD_NVM_GO = 15;
  localparam int SEC_LOCK = 0;
  localparam int SEC_WRP = 1;
  localparam int SEC_RDP = 2;
  localparam int SEC_TEL = 3;
  // Codes and values
  localparam logic [7:0] PMB_CMD_INDIRECT = 8'hD0;
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [15:0] READ_REFUSED = 16'hFFFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {SRAC_IDLE, SRAC_RXB, SRAC_ACK, SRAC_TXB, SRAC_TXACK} srac_st_t;
  typedef enum logic [1:0] {SRAC_K_ADDR, SRAC_K_CMD, SRAC_K_IDX, SRAC_K_DATA} srac_kind_t;

  typedef struct packed {
    logic req;
    logic [7:0] idx;
    logic [15:0] data;
  } srac_nvm_t;

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic [3:0] ofs_m;
    logic [3:0] ofs_s;
    logic booted;
    srac_st_t st;
    srac_kind_t kind;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic hi;
    logic ack;
    logic [7:0] idx;
    logic [7:0] lo_byte;
    logic [15:0] txw;
    logic unlocked;
    logic drv_low;
    logic test_mode;
    srac_nvm_t nvm;
  } srac_state_t;
endpackage : srac_pkg
`default_nettype wire

// ===== rtl/srac_slave.sv
// Two-wire slave with register and indirect-command addresses and access control.
// Assumes open-drain bus resolved outside; config store and telemetry on mclk.
`default_nettype none
// Operation
// R1 - Bus runs correctly up to 1 MHz clock; the bench host runs above that (it clocks bits at 125 ns, 8 MHz).
// R2 - Registers readable and writable over the bus; config store programmable.
// R3 - Base slave address is loaded from the config store after reset.
// R4 - Effective address is base field plus the pin-selected offset.
// R5 - With offset disabled, device answers exactly at base field.
// R6 - Password lock refuses access until the 16-bit password is given.
// R7 - Limited access can block writes, reads, or both independently.
// R8 - Telemetry-only mode accepts only telemetry reads; all else refused.
// R9 - Command D0h on the command address gives indirect register access.
// R10 - Command-address base field of zero disables that address entirely.
// R11 - Register-address base field of zero forces test mode.
// R12 - Host software must not assign reserved slave addresses.
// R13 - Address lock bit blocks writes to the base address register.
// R14 - Address config bit six disables the pin offset for both addresses.
// R15 - Two independent addresses decoded; only enabled matches are acknowledged.
module srac_slave
  import srac_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] addr_program_select_pin,
  input wire logic [15:0] nvm_base_addr,
  input wire logic [TEL_N-1:0][15:0] telem_in,
  output srac_nvm_t nvm_prog,
  output logic test_mode
);

  srac_state_t s_q;
  srac_state_t s_d;
  logic [15:0] mem_q [0:255];
  logic wr_en;
  logic [7:0] wr_idx;
  logic [15:0] wr_data;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [6:0] i2c_eff;
  logic [6:0] pmb_eff;
  logic match_i2c;
  logic match_pmb;
  logic [15:0] sec;

  // Base field plus pin offset unless the offset is disabled
  function automatic logic [6:0] eff_addr(input logic [6:0] base, input logic [3:0] ofs,
                                          input logic dis);
    eff_addr = dis ? base : base + {3'h0, ofs};
  endfunction : eff_addr

  // Access policy for one register access
  function automatic logic acc_ok(input logic rd, input logic [7:0] i, input logic [15:0] sc,
                                  input logic unl);
    logic tel;
    tel = (i >= OFS_TEL_LO) && (i <= OFS_TEL_HI);
    if (sc[SEC_TEL]) begin
      acc_ok = rd && tel; // [R8]
    end else if (sc[SEC_LOCK] && !unl) begin
      acc_ok = !rd && (i == OFS_PWD_KEY); // [R6]
    end else begin
      acc_ok = rd ? !sc[SEC_RDP] : !sc[SEC_WRP]; // [R7]
    end
  endfunction : acc_ok

  // Read value of one register as seen by the bus
  function automatic logic [15:0] rd_word(input logic [7:0] i, input logic [15:0] sc,
                                          input logic unl);
    if (!acc_ok(1'b1, i, sc, unl)) begin
      rd_word = READ_REFUSED;
    end else if ((i >= OFS_TEL_LO) && (i <= OFS_TEL_HI)) begin
      rd_word = telem_in[i[2:0]];
    end else if ((i == OFS_PWD_KEY) || (i == OFS_PWD_STORE)) begin
      rd_word = RST_REG;
    end else begin
      rd_word = mem_q[i]; // [R2]
    end
  endfunction : rd_word

  // Bus edges and conditions from the synchronised pins
  assign rise = s_q.scl_sy[1] && !s_q.scl_sy[2]; // [R1]
  assign fall = !s_q.scl_sy[1] && s_q.scl_sy[2];
  assign start = s_q.scl_sy[1] && s_q.scl_sy[2] && s_q.sda_sy[2] && !s_q.sda_sy[1];
  assign stop = s_q.scl_sy[1] && s_q.scl_sy[2] && !s_q.sda_sy[2] && s_q.sda_sy[1];

  // Address decode for both slave addresses
  assign i2c_eff = eff_addr(mem_q[OFS_BASE_ADDR][FLD_I2C_LSB +: 7], s_q.ofs_s,
                            mem_q[OFS_ADDR_CFG][FLD_OFS_DIS]); // [R4] [R5] [R14]
  assign pmb_eff = eff_addr(mem_q[OFS_BASE_ADDR][FLD_PMB_LSB +: 7], s_q.ofs_s,
                            mem_q[OFS_ADDR_CFG][FLD_OFS_DIS]); // [R4] [R5] [R14]
  assign match_i2c = !s_q.test_mode && (s_q.sh[7:1] == i2c_eff); // [R15]
  assign match_pmb = (mem_q[OFS_BASE_ADDR][FLD_PMB_LSB +: 7] != 7'h00)
                     && (s_q.sh[7:1] == pmb_eff); // [R10]
  assign sec = mem_q[OFS_SEC_CTRL];

  // Outputs: open-drain data, pulled only low
  assign sda_out = 1'b0;
  assign sda_oe = s_q.drv_low;
  assign nvm_prog = s_q.nvm;
  assign test_mode = s_q.test_mode;

  // Next-state logic of the slave
  always_comb begin
    s_d = s_q;
    wr_en = 1'b0;
    wr_idx = s_q.idx;
    wr_data = {s_q.sh, s_q.lo_byte};
    s_d.scl_sy = {s_q.scl_sy[1:0], scl_in}; // [R1]
    s_d.sda_sy = {s_q.sda_sy[1:0], sda_in};
    s_d.ofs_m = addr_program_select_pin;
    s_d.ofs_s = s_q.ofs_m;
    s_d.nvm.req = 1'b0;
    s_d.test_mode = mem_q[OFS_BASE_ADDR][FLD_I2C_LSB +: 7] == 7'h00; // [R11]
    if (!s_q.booted) begin
      wr_en = 1'b1; // [R3]
      wr_idx = OFS_BASE_ADDR;
      wr_data = nvm_base_addr;
      s_d.booted = 1'b1;
    end else if (start) begin
      s_d.st = SRAC_RXB;
      s_d.kind = SRAC_K_ADDR;
      s_d.bits = 4'h0;
      s_d.drv_low = 1'b0;
    end else if (stop) begin
      s_d.st = SRAC_IDLE;
      s_d.drv_low = 1'b0;
    end else begin
      case (s_q.st)
        SRAC_RXB: begin
          if (rise) begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_sy[1]};
            s_d.bits = s_q.bits + 4'h1;
          end else if (fall && (s_q.bits == BITS_PER_BYTE)) begin
            s_d.st = SRAC_ACK;
            s_d.bits = 4'h0;
            case (s_q.kind)
              SRAC_K_ADDR: begin
                s_d.ack = match_i2c || match_pmb; // [R15]
                s_d.rw = s_q.sh[0];
                s_d.hi = 1'b0;
                s_d.kind = s_q.sh[0] ? SRAC_K_DATA : (match_pmb ? SRAC_K_CMD : SRAC_K_IDX);
              end
              SRAC_K_CMD: begin
                s_d.ack = s_q.sh == PMB_CMD_INDIRECT; // [R9]
                s_d.kind = SRAC_K_IDX;
              end
              SRAC_K_IDX: begin
                s_d.ack = 1'b1;
                s_d.idx = s_q.sh;
                s_d.hi = 1'b0;
                s_d.kind = SRAC_K_DATA;
              end
              default: begin
                s_d.ack = acc_ok(1'b0, s_q.idx, sec, s_q.unlocked)
                          && !((s_q.idx == OFS_BASE_ADDR)
                               && mem_q[OFS_ADDR_LOCK][FLD_ADDR_LOCK]); // [R13]
                if (!s_q.hi) begin
                  s_d.lo_byte = s_q.sh;
                  s_d.hi = 1'b1;
                end else begin
                  wr_en = s_d.ack; // [R2]
                  s_d.idx = s_q.idx + 8'h01;
                  s_d.hi = 1'b0;
                end
              end
            endcase
            s_d.drv_low = s_d.ack;
          end
        end
        SRAC_ACK: begin
          if (fall) begin
            s_d.drv_low = 1'b0;
            if (!s_q.ack) begin
              s_d.st = SRAC_IDLE;
            end else if (s_q.kind == SRAC_K_DATA && s_q.rw) begin
              s_d.st = SRAC_TXB;
              s_d.txw = rd_word(s_q.idx, sec, s_q.unlocked);
              s_d.sh = s_d.txw[7:0];
              s_d.drv_low = !s_d.txw[7];
            end else begin
              s_d.st = SRAC_RXB;
            end
          end
        end
        SRAC_TXB: begin
          if (rise) begin
            s_d.bits = s_q.bits + 4'h1;
          end else if (fall && (s_q.bits == BITS_PER_BYTE)) begin
            s_d.st = SRAC_TXACK;
            s_d.bits = 4'h0;
            s_d.drv_low = 1'b0;
          end else if (fall) begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.drv_low = !s_q.sh[6];
          end
        end
        SRAC_TXACK: begin
          if (rise) begin
            s_d.ack = !s_q.sda_sy[1];
          end else if (fall) begin
            if (!s_q.ack) begin
              s_d.st = SRAC_IDLE;
            end else if (!s_q.hi) begin
              s_d.st = SRAC_TXB;
              s_d.hi = 1'b1;
              s_d.sh = s_q.txw[15:8];
              s_d.drv_low = !s_q.txw[15];
            end else begin
              s_d.st = SRAC_TXB;
              s_d.hi = 1'b0;
              s_d.idx = s_q.idx + 8'h01;
              s_d.txw = rd_word(s_q.idx + 8'h01, sec, s_q.unlocked);
              s_d.sh = s_d.txw[7:0];
              s_d.drv_low = !s_d.txw[7];
            end
          end
        end
        default: begin
          s_d.drv_low = 1'b0;
        end
      endcase
    end
    // Side effects of a committed bus write
    if (wr_en && s_q.booted) begin
      if (wr_idx == OFS_PWD_KEY) begin
        s_d.unlocked = wr_data == mem_q[OFS_PWD_STORE]; // [R6]
      end
      if ((wr_idx == OFS_NVM_PROG) && wr_data[FLD_NVM_GO]) begin
        s_d.nvm.req = 1'b1; // [R2]
        s_d.nvm.idx = wr_data[7:0];
        s_d.nvm.data = mem_q[wr_data[7:0]];
      end
    end
  end

  // State and register file
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= RST_REG;
      end
    end else begin
      s_q <= s_d;
      if (wr_en) begin
        mem_q[wr_idx] <= wr_data;
      end
    end
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_boot_base_load: assert property (!s_q.booted // [R3]
    |=> mem_q[OFS_BASE_ADDR] == $past(nvm_base_addr))
    else $error("base address not loaded from store");
  a_addr_lock_wr: assert property (wr_en && s_q.booted && wr_idx == OFS_BASE_ADDR // [R13]
    |-> !mem_q[OFS_ADDR_LOCK][FLD_ADDR_LOCK])
    else $error("locked address register written");
  a_tel_only_wr: assert property (wr_en && s_q.booted |-> !sec[SEC_TEL]) // [R8]
    else $error("write accepted in telemetry-only mode");
  a_wp_blocks_wr: assert property (wr_en && s_q.booted |-> !sec[SEC_WRP]) // [R7]
    else $error("write accepted under write protection");
  a_locked_key_only: assert property (wr_en && s_q.booted && sec[SEC_LOCK] && !s_q.unlocked // [R6]
    |-> wr_idx == OFS_PWD_KEY)
    else $error("locked device accepted other write");
  a_test_mode_zero: assert property (mem_q[OFS_BASE_ADDR][FLD_I2C_LSB +: 7] == 7'h00 // [R11]
    |=> test_mode)
    else $error("test mode not entered");
  a_pmb_disabled: assert property (s_q.st == SRAC_RXB && s_q.kind == SRAC_K_ADDR && fall // [R10]
    && s_q.bits == BITS_PER_BYTE && mem_q[OFS_BASE_ADDR][FLD_PMB_LSB +: 7] == 7'h00 && !match_i2c
    |=> !sda_oe)
    else $error("disabled command address acknowledged");
  a_addr_ack: assert property (s_q.st == SRAC_RXB && s_q.kind == SRAC_K_ADDR && fall // [R4]
    && s_q.bits == BITS_PER_BYTE && match_i2c |=> sda_oe && s_q.st == SRAC_ACK)
    else $error("own address not acknowledged");
  a_cmd_code: assert property (s_q.st == SRAC_RXB && s_q.kind == SRAC_K_CMD && fall // [R9]
    && s_q.bits == BITS_PER_BYTE && s_q.sh != PMB_CMD_INDIRECT |=> !sda_oe)
    else $error("unknown command acknowledged");
  a_nvm_pulse: assert property (nvm_prog.req |=> !nvm_prog.req) // [R2]
    else $error("program request longer than one cycle");
  a_oe_in_phase: assert property (sda_oe |-> s_q.st == SRAC_ACK || s_q.st == SRAC_TXB) // [R15]
    else $error("data line driven outside answer phase");

  c_reg_write: cover property (wr_en && s_q.booted);
  c_read_word: cover property (s_q.st == SRAC_TXACK && s_q.hi && fall);
  c_cmd_ack: cover property (s_q.kind == SRAC_K_IDX && s_q.st == SRAC_ACK && s_q.ack);
  c_nvm_prog: cover property (nvm_prog.req);

endmodule : srac_slave
`default_nettype wire

// ===== testbench/srac_host.sv
// Bus host model: clock driven directly, data open-drain, register writes and reads.
// Assumes the bench resolves the data line with a pull-up.
`default_nettype none
module srac_host (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Step n clocks, then move off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // Start (s=0) or stop (s=1); long waits let the device drop its ack first
  task automatic cond(input logic s);
    sda_low = s;
    tick(12);
    scl = 1'b1;
    tick(12);
    sda_low = ~s;
    tick(12);
    scl = s;
  endtask : cond
  // One bit in 25 clocks (125 ns): set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    tick(6);
    sda_low = ~b;
    tick(6);
    scl = 1'b1;
    tick(6);
    r = sda;
    tick(7);
    scl = 1'b0;
  endtask : bit_io
  // Eight data bits and the acknowledge bit
  task automatic byte_io(input logic [8:0] d, output logic [7:0] q, output logic ack);
    logic [8:0] r;
    for (int i = 8; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    q = r[8:1];
    ack = ~r[0];
  endtask : byte_io
  // Write: address, command code if not zero, index, low then high byte
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] idx,
    input logic [15:0] d, output logic [4:0] ak);
    logic [7:0] q;
    ak[3] = 1'b1;
    cond(1'b0);
    byte_io({a, 2'b01}, q, ak[4]);
    if (c != 8'h00) begin
      byte_io({c, 1'b1}, q, ak[3]);
    end
    byte_io({idx, 1'b1}, q, ak[2]);
    byte_io({d[7:0], 1'b1}, q, ak[1]);
    byte_io({d[15:8], 1'b1}, q, ak[0]);
    cond(1'b1);
  endtask : wr
  // Read: index, repeated start, low byte acked, high byte refused
  task automatic rd(input logic [6:0] a, input logic [7:0] idx, output logic [15:0] d);
    logic [7:0] q;
    logic ak;
    cond(1'b0);
    byte_io({a, 2'b01}, q, ak);
    byte_io({idx, 1'b1}, q, ak);
    cond(1'b0);
    byte_io({a, 2'b11}, q, ak);
    byte_io(9'h1FE, d[7:0], ak);
    byte_io(9'h1FF, d[15:8], ak);
    cond(1'b1);
  endtask : rd
endmodule : srac_host
`default_nettype wire

// ===== testbench/srac_slave_test.sv
// Bench: address decode, access guards and store path of the slave.
// Assumes srac_pkg and the host model are compiled first.
`default_nettype none
module srac_slave_test
  import srac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, sda_out, sda_oe, scl, host_low, test_mode;
  logic [3:0] pin_ofs;
  logic [15:0] base_img, w;
  logic [TEL_N-1:0][15:0] telem;
  logic [4:0] k;
  wire logic sda;
  srac_nvm_t nvm_prog, nv_seen;
  int failures, checks_done, nv_hits;
  // Open-drain data line with pull-up
  assign sda = ~(host_low | (sda_oe & ~sda_out));
  srac_slave srac_slave_inst (
    .mclk(mclk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_program_select_pin(pin_ofs), .nvm_base_addr(base_img), .telem_in(telem),
    .nvm_prog(nvm_prog), .test_mode(test_mode));
  srac_host srac_host_inst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(host_low));
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Store pulses last one clock, so catch them here
  always @(posedge mclk) begin
    if (nvm_prog.req === 1'b1) begin
      nv_hits++;
      nv_seen = nvm_prog;
    end
  end
  // Hang guard, about twice the expected run
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    conclude();
  end
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Reset for 12 clocks; first frame 4 clocks after release
  task automatic reset_dut();
    nrst = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    nrst = 1'b1;
    srac_host_inst.tick(4);
  endtask : reset_dut
  // Offset address, then base alone once the offset is off
  task automatic t_addr();
    srac_host_inst.wr(7'h23, 8'h00, OFS_ADDR_CFG, 16'h0040, k);
    chk("cfg acks", 16'h001F, {11'h0, k});
    chk("drive level", 16'h0000, {15'h0, sda_out});
    srac_host_inst.rd(7'h20, OFS_ADDR_CFG, w);
    chk("cfg read", 16'h0040, w);
    srac_host_inst.wr(7'h23, 8'h00, OFS_ADDR_CFG, 16'h0040, k);
    chk("stale ack", 16'h0000, {15'h0, k[4]});
    srac_host_inst.rd(7'h20, OFS_BASE_ADDR, w);
    chk("base", 16'h2030, w);
    $display("t_addr done");
  endtask : t_addr
  // Indirect store program, wrong code, command address off
  task automatic t_cmd();
    srac_host_inst.wr(7'h20, 8'h00, 8'h12, 16'h5AA5, k);
    srac_host_inst.wr(7'h30, PMB_CMD_INDIRECT, OFS_NVM_PROG, 16'h8012, k);
    chk("cmd acks", 16'h001F, {11'h0, k});
    chk("pulses", 16'h0001, 16'(nv_hits));
    chk("store idx", 16'h0012, {8'h0, nv_seen.idx});
    chk("store data", 16'h5AA5, nv_seen.data);
    srac_host_inst.wr(7'h30, 8'hD1, OFS_NVM_PROG, 16'h8013, k);
    chk("bad cmd ack", 16'h0000, {15'h0, k[3]});
    chk("pulses", 16'h0001, 16'(nv_hits));
    srac_host_inst.wr(7'h20, 8'h00, OFS_BASE_ADDR, 16'h2000, k);
    srac_host_inst.wr(7'h00, PMB_CMD_INDIRECT, OFS_NVM_PROG, 16'h8014, k);
    chk("cmd off ack", 16'h0000, {15'h0, k[4]});
    $display("t_cmd done");
  endtask : t_cmd
  // Address lock, password, read guard, telemetry-only
  task automatic t_guard();
    srac_host_inst.wr(7'h20, 8'h00, OFS_ADDR_LOCK, 16'h0004, k);
    srac_host_inst.wr(7'h20, 8'h00, OFS_BASE_ADDR, 16'h0000, k);
    chk("lock ack", 16'h0000, {15'h0, k[0]});
    srac_host_inst.wr(7'h20, 8'h00, OFS_SEC_CTRL, 16'h0001, k);
    srac_host_inst.rd(7'h20, OFS_ADDR_CFG, w);
    chk("locked", READ_REFUSED, w);
    srac_host_inst.wr(7'h20, 8'h00, OFS_PWD_KEY, 16'h0000, k);
    srac_host_inst.rd(7'h20, OFS_ADDR_CFG, w);
    chk("unlocked", 16'h0040, w);
    srac_host_inst.wr(7'h20, 8'h00, OFS_PWD_KEY, 16'h1234, k);
    srac_host_inst.rd(7'h20, OFS_ADDR_CFG, w);
    chk("wrong key", READ_REFUSED, w);
    srac_host_inst.wr(7'h20, 8'h00, OFS_PWD_KEY, 16'h0000, k);
    srac_host_inst.wr(7'h20, 8'h00, OFS_SEC_CTRL, 16'h0004, k);
    srac_host_inst.rd(7'h20, OFS_ADDR_CFG, w);
    chk("read guard", READ_REFUSED, w);
    srac_host_inst.wr(7'h20, 8'h00, OFS_SEC_CTRL, 16'h0008, k);
    srac_host_inst.rd(7'h20, OFS_TEL_HI, w);
    chk("telemetry", 16'hA5C7, w);
    $display("t_guard done");
  endtask : t_guard
  // Zero register base after a fresh reset
  task automatic t_test();
    base_img = 16'h0030;
    reset_dut();
    chk("test_mode", 16'h0001, {15'h0, test_mode});
    srac_host_inst.wr(7'h03, 8'h00, OFS_ADDR_CFG, 16'h0040, k);
    chk("test ack", 16'h0000, {15'h0, k[4]});
    srac_host_inst.wr(7'h33, PMB_CMD_INDIRECT, OFS_SEC_CTRL, 16'h0002, k);
    chk("test cmd acks", 16'h001F, {11'h0, k});
    srac_host_inst.wr(7'h33, PMB_CMD_INDIRECT, OFS_ADDR_CFG, 16'h0040, k);
    chk("write guard", 16'h0000, {15'h0, k[1]});
    $display("t_test done");
  endtask : t_test
  // Main sequence
  initial begin
    pin_ofs = 4'h3;
    base_img = 16'h2030;  // Register 0x20, command 0x30, both unreserved
    for (int i = 0; i < TEL_N; i++) begin
      telem[i] = 16'hA5C0 + 16'(i);
    end
    reset_dut();
    t_addr();
    t_cmd();
    t_guard();
    t_test();
    conclude();
  end
endmodule : srac_slave_test
`default_nettype wire
